// >>> xpsc_top.v
/*
 * Crosspoint switch control: first and second rank command registers,
 * serial chain and parallel decode, reached over an AHB-Lite slave.
 * Assumes one clock, synchronous active-low reset, word accesses only.
 */
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "xpsc_regs.vh"

module xpsc_top (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Switch state
	output reg  [31:0] video_outputs_route,
	output reg  [7:0]  video_outputs_enable,
	output reg         serial_out
);

////////////////////////////////////////////////////////////////////////
// Bus address phase capture

reg                      wr_pend_q;
reg                      rd_pend_q;
reg [`XPSC_ADDR_W-1:0]   addr_q;
reg [4:0]                ctrl_q;
reg [31:0]               first_q;
reg [31:0]               second_q;
reg [7:0]                enable_q;
reg                      latch_prev_q;
reg                      blocked_q;

wire take = hsel && hready && (htrans == `XPSC_HTRANS_NSEQ);

wire ser_mode = ctrl_q[`XPSC_CTRL_SER];
wire edge_md  = ctrl_q[`XPSC_CTRL_EDGE];
wire latch_ln = ctrl_q[`XPSC_CTRL_LATCH];
wire chip_en  = ctrl_q[`XPSC_CTRL_CE] && !ctrl_q[`XPSC_CTRL_CE_N];

// Strobe: a write of the command register with its strobe bit set while chip_en is true
wire cmd_wr  = wr_pend_q && (addr_q == `XPSC_OFS_CMD);
wire strobe  = cmd_wr && hwdata[`XPSC_CMD_STROBE] && chip_en;
wire [2:0] sel_out = hwdata[6:4];
wire [3:0] pdata   = hwdata[3:0];

// Reads the 4-bit slot of one output from a 32-bit rank
function [3:0] slot;
	input [31:0] rank;
	input [2:0]  idx;
	begin
		slot = rank[idx*4 +: 4];
	end
endfunction

// Any serial code above the disable code blocks the transfer
function blocks;
	input [31:0] rank;
	integer i;
	begin
		blocks = 1'b0;
		for (i = 0; i < `XPSC_NOUT; i = i + 1) begin
			if (rank[i*4 +: 4] > `XPSC_CODE_OFF) begin
				blocks = 1'b1;
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Latch control

wire ctrl_wr  = wr_pend_q && (addr_q == `XPSC_OFS_CTRL);
wire latch_nx = ctrl_wr ? hwdata[`XPSC_CTRL_LATCH] : latch_ln;
wire lat_rise = latch_nx && !latch_prev_q;
wire sw_latch = strobe && !ser_mode && (pdata == `XPSC_CODE_SWLAT)
	&& latch_ln;
wire do_xfer  = edge_md ? lat_rise : !latch_nx;

////////////////////////////////////////////////////////////////////////
// First rank

reg [31:0] first_d;
always @* begin
	first_d = first_q;
	if (strobe) begin
		if (ser_mode) begin
			// MSB of output 0 enters first and ends at the top
			first_d = {first_q[30:0], hwdata[`XPSC_CMD_SDI]};
		end else if (!pdata[`XPSC_TOP] ||
			(pdata == `XPSC_CODE_GND)) begin
			// Output 0 sits in the top nibble, like the serial order
			first_d[(7-sel_out)*4 +: 4] = pdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Second rank and buffer enables

reg [31:0] second_d;
reg [7:0]  enable_d;
integer k;
always @* begin
	second_d = second_q;
	enable_d = enable_q;
	if (strobe && !ser_mode && pdata[`XPSC_TOP]) begin
		case (pdata)
			`XPSC_CODE_P_OFF:  enable_d[sel_out] = 1'b0;
			`XPSC_CODE_P_ON:   enable_d[sel_out] = 1'b1;
			`XPSC_CODE_ALLOFF: enable_d = 8'h00;
			`XPSC_CODE_ALLON:  enable_d = 8'hff;
			default:           enable_d = enable_q;
		endcase
	end
	if ((do_xfer && !(ser_mode && blocks(first_d))) || sw_latch) begin
		for (k = 0; k < `XPSC_NOUT; k = k + 1) begin
			case (slot(first_d, 3'd7 - k[2:0]))
				`XPSC_CODE_GND: begin
					second_d[k*4 +: 4] = `XPSC_CODE_GND;
				end
				`XPSC_CODE_ON: begin
					second_d[k*4 +: 4] = `XPSC_CODE_GND;
					enable_d[k] = 1'b1;
				end
				`XPSC_CODE_OFF: begin
					second_d[k*4 +: 4] = `XPSC_CODE_OFF;
					enable_d[k] = 1'b0;
				end
				default: begin
					if (slot(first_d, 3'd7 - k[2:0]) <= `XPSC_CODE_MAXIN) begin
						second_d[k*4 +: 4] = slot(first_d, 3'd7 - k[2:0]);
					end
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge sys_clk) begin
	if (!rst_n) begin
		wr_pend_q    <= 1'b0;
		rd_pend_q    <= 1'b0;
		addr_q       <= {`XPSC_ADDR_W{1'b0}};
		ctrl_q       <= `XPSC_CTRL_RST;
		first_q      <= 32'h0000_0000;
		second_q     <= 32'h0000_0000;
		enable_q     <= 8'h00;
		latch_prev_q <= 1'b1;
		blocked_q    <= 1'b0;
		hrdata       <= 32'h0000_0000;
		hreadyout    <= 1'b1;
		hresp        <= 1'b0;
		video_outputs_route  <= 32'h0000_0000;
		video_outputs_enable <= 8'h00;
		serial_out   <= 1'b0;
	end else begin
		wr_pend_q <= take && hwrite;
		rd_pend_q <= take && !hwrite;
		if (take) begin
			addr_q <= haddr[`XPSC_ADDR_W-1:0];
		end
		if (ctrl_wr) begin
			ctrl_q <= hwdata[4:0];
		end
		latch_prev_q <= latch_nx;
		first_q      <= first_d;
		second_q     <= second_d;
		enable_q     <= enable_d;
		blocked_q    <= ser_mode && blocks(first_d);
		video_outputs_route  <= second_d;
		video_outputs_enable <= enable_d;
		serial_out   <= first_d[`XPSC_CHAIN_W-1];
		hreadyout    <= 1'b1;
		hresp        <= 1'b0;
		if (take && !hwrite) begin
			case (haddr[`XPSC_ADDR_W-1:0])
				`XPSC_OFS_CTRL:   hrdata <= {27'h0, ctrl_q};
				`XPSC_OFS_FIRST:  hrdata <= first_q;
				`XPSC_OFS_SECOND: hrdata <= second_q;
				`XPSC_OFS_ENABLE: hrdata <= {24'h0, enable_q};
				`XPSC_OFS_STATUS: hrdata <= {30'h0, blocked_q, serial_out};
				default:          hrdata <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule
`default_nettype wire

// >>> xpsc_regs.vh
/*
 * Constants for the crosspoint switch control block: register map,
 * command codes, field positions and reset values.
 * Assumes inclusion by the single design file; definitions only.
 */
// Behaviour
// - Serial codes 0-7 route buffer to input
// - Serial 1000 grounds input, enable unchanged
// - Serial 1001 enables buffer, grounds input
// - All buffers disabled after reset
// - Serial 1010 disables buffer, slot holds 1010
// - Serial codes 1011-1111 block second-rank transfer
// - Select high serial, low parallel
// - Parallel: address selects buffer, top bit selects kind
// - Strobe rising edge captures into first rank
// - Latch rising copies whole first rank at once
// - Parallel write changes exactly one entry
// - Serial load 32 bits, MSB first, out0 first
// - Strobe qualified by both chip enables
// - Edge mode on rise, level mode while low
// - Parallel 1111 acts as software latch, only while the latch bit is high
`ifndef XPSC_REGS_VH
`define XPSC_REGS_VH

// Register byte offsets
`define XPSC_OFS_CTRL    8'h00
`define XPSC_OFS_CMD     8'h04
`define XPSC_OFS_FIRST   8'h08
`define XPSC_OFS_SECOND  8'h0c
`define XPSC_OFS_ENABLE  8'h10
`define XPSC_OFS_STATUS  8'h14

// Control register fields
`define XPSC_CTRL_SER    0
`define XPSC_CTRL_EDGE   1
`define XPSC_CTRL_CE     2
`define XPSC_CTRL_CE_N   3
`define XPSC_CTRL_LATCH  4
`define XPSC_CTRL_RST    5'h1a

// Command register fields
`define XPSC_CMD_STROBE  16
`define XPSC_CMD_SDI     0

// Command codes
`define XPSC_CODE_MAXIN  4'h7
`define XPSC_CODE_GND    4'h8
`define XPSC_CODE_ON     4'h9
`define XPSC_CODE_OFF    4'ha
`define XPSC_CODE_P_OFF  4'hb
`define XPSC_CODE_P_ON   4'hc
`define XPSC_CODE_ALLOFF 4'hd
`define XPSC_CODE_ALLON  4'he
`define XPSC_CODE_SWLAT  4'hf
`define XPSC_TOP         3

`define XPSC_CHAIN_W     32
`define XPSC_NOUT        8

// AHB constants
`define XPSC_HTRANS_NSEQ 2'b10
`define XPSC_ADDR_W      8

`endif

// >>> xpsc_top_checker.sv
/* Port assertions for the switch control block.
   Assumes a bind onto xpsc_top and a single clock. */
`timescale 1ns/10ps
`default_nettype none
module xpsc_top_checker (
	// Clock, reset and bus
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Switch state
	input wire logic [31:0] video_outputs_route,
	input wire logic [7:0]  video_outputs_enable,
	input wire logic        serial_out
);
	logic wr_q;
	logic rd_q;
	logic far_q;
	wire  sel = rst_n && hsel && hready && htrans[1];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Data phase flags
	always @(posedge sys_clk) begin
		wr_q  <= sel && hwrite;
		rd_q  <= sel && !hwrite;
		far_q <= haddr[7:0] > 8'h14;
	end
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_reset_off: assert property (disable iff (1'b0)
		!rst_n |=> video_outputs_enable == 8'h00) else $error("enable on");
	chk_reset_route: assert property (disable iff (1'b0)
		!rst_n |=> video_outputs_route == 32'h0) else $error("route set");
	chk_route_hold: assert property (!wr_q && !$past(wr_q)
		|-> $stable(video_outputs_route)) else $error("route moved");
	chk_enable_hold: assert property (!wr_q && !$past(wr_q)
		|-> $stable(video_outputs_enable)) else $error("enable moved");
	chk_serial_hold: assert property (!wr_q && !$past(wr_q)
		|-> $stable(serial_out)) else $error("serial out moved");
	chk_far_zero: assert property (rd_q && far_q |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	cover property (wr_q);
	cover property (rd_q && far_q);
	cover property (video_outputs_enable == 8'hff);
endmodule
`default_nettype wire

// >>> xpsc_host.sv
/* AHB-Lite master model that issues the host commands.
   Assumes one slave whose hreadyout is fed back as hready. */
`timescale 1ns/10ps
`default_nettype none
module xpsc_host (
	// Clock
	input  wire logic        sys_clk,
	// AHB-Lite master side
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata,
	input  wire logic [31:0] hrdata,
	input  wire logic        hready
);
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
	end
	// Holds each phase until hready is seen high
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule
`default_nettype wire

// >>> xpsc_top_tb.sv
/* Self-checking bench for the switch control block.
   Assumes the host model and the checker files compile first. */
`timescale 1ns/10ps
`default_nettype none
module xpsc_top_tb;
	logic        sys_clk = 0;
	logic        rst_n = 0;
	logic        hsel, hwrite, hready, hresp, sout;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  en;
	logic [31:0] haddr, hwdata, hrdata, route, r, w, exp_r;
	logic [31:0] lf = 32'hbbc5;
	int          failures = 0, tests_run = 0, cyc = 0, i;
	always #5 sys_clk = ~sys_clk;
	xpsc_host u_xpsc_host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hrdata(hrdata), .hready(hready));
	xpsc_top u_xpsc_top (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hresp(hresp),
		.hreadyout(hready), .video_outputs_route(route),
		.video_outputs_enable(en), .serial_out(sout));
	function automatic logic [3:0] rnd3();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return {1'b0, lf[2:0]};
	endfunction
	// Serial word has output 0 in its top nibble
	function automatic logic [31:0] to_route(input logic [31:0] s);
		for (int k = 0; k < 8; k++) to_route[4*k+:4] = s[31-4*k-:4];
	endfunction
	task check(input logic [31:0] seen, want, input string what);
		repeat (2) @(negedge sys_clk);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, want, seen);
		end
	endtask
	// Waits past the data-phase edge so outputs have settled
	task wr(input logic [31:0] a, d);
		u_xpsc_host.xfer(a, 1, d, r);
		@(negedge sys_clk);
	endtask
	task latch(input logic [31:0] c);
		wr(0, c & ~32'h10);
		wr(0, c);
	endtask
	task shift(input logic [31:0] s);
		for (int b = 31; b >= 0; b--) wr(4, 32'h10000 | s[b]);
	endtask
	task stop_test;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures = failures + 1;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1;
		check(en, 0, "enable");
		u_xpsc_host.xfer(32'h18, 0, 0, r);
		check(r, 0, "unmapped");
		wr(0, 32'h16);
		for (i = 0; i < 8; i++) begin
			exp_r[4*i+:4] = rnd3();
			wr(4, 32'h10000 | i << 4 | exp_r[4*i+:4]);
		end
		check(route, 0, "route early");
		latch(32'h16);
		check(route, exp_r, "route");
		for (i = 0; i < 2; i++) begin
			wr(0, i ? 32'h1e : 32'h12);
			wr(4, 32'h10000 | {29'h0, ~exp_r[2:0]});
			latch(i ? 32'h1e : 32'h12);
			check(route, exp_r, "ce off");
		end
		wr(0, 32'h16);
		exp_r[7:4] ^= 4'h1;
		wr(4, 32'h10010 | exp_r[7:4]);
		wr(4, 32'h1000f);
		check(route, exp_r, "soft latch");
		wr(0, 32'h17);
		shift(32'h99999999);
		latch(32'h17);
		check(en, 8'hff, "enable");
		check(sout, 1, "serial out");
		for (i = 0; i < 8; i++) w[4*i+:4] = rnd3();
		w[19:16] = 4'ha;
		shift(w);
		latch(32'h17);
		check(route, to_route(w), "route");
		check(en, 8'hf7, "enable");
		shift(32'h8888888b);
		latch(32'h17);
		check(route, to_route(w), "blocked");
		shift(32'h88888888);
		latch(32'h17);
		check(route, 32'h88888888, "ground");
		check(en, 8'hf7, "enable");
		wr(0, 32'h15);
		shift(32'h01234567);
		check(route, 32'h88888888, "level hold");
		wr(0, 32'h05);
		check(route, to_route(32'h01234567), "level");
		stop_test;
	end
endmodule
bind xpsc_top xpsc_top_checker u_xpsc_top_checker (.sys_clk(sys_clk),
	.rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp),
	.video_outputs_route(video_outputs_route),
	.video_outputs_enable(video_outputs_enable), .serial_out(serial_out));
`default_nettype wire
